// ---- include/tmc_cfg.svh ----
// Timer core constants: register indices, field positions, reset values
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// Byte register indices on the core's register port
`define TMC_IDX_CTRL0   3'h0
`define TMC_IDX_CTRL1   3'h1
`define TMC_IDX_CNT_LO  3'h2
`define TMC_IDX_CNT_HI  3'h3
`define TMC_IDX_CMPA_LO 3'h4
`define TMC_IDX_CMPA_HI 3'h5
`define TMC_IDX_PER_LO  3'h6
`define TMC_IDX_PER_HI  3'h7

// Control 0 fields
`define TMC_C0_PAUSE    7
`define TMC_C0_CKS_HI   6
`define TMC_C0_CKS_LO   4
`define TMC_C0_ON       3
// Control 1 fields
`define TMC_C1_MODE_HI  7
`define TMC_C1_MODE_LO  6
`define TMC_C1_IO_HI    5
`define TMC_C1_IO_LO    4
`define TMC_C1_OC       3
`define TMC_C1_POL      2
`define TMC_C1_DPX      1
`define TMC_C1_CCLR     0

`define TMC_CTRL0_RST   8'h00
`define TMC_CTRL1_RST   8'h00
`define TMC_CTRL0_MASK  8'hF8

// Prescale divisors used by the internal clock choices
`define TMC_DIV_SYS4    4
`define TMC_DIV_H16     16
`define TMC_DIV_H64     64

`endif

// ---- include/tmc_pkg.sv ----
// Timer core types
package tmc_pkg;

    typedef enum logic [1:0] {
        TMC_MODE_CMP   = 2'h0,
        TMC_MODE_UNDEF = 2'h1,
        TMC_MODE_PWM   = 2'h2,
        TMC_MODE_TIMER = 2'h3
    } tmc_mode_t;

    typedef enum logic [2:0] {
        TMC_CK_SYS4  = 3'h0,
        TMC_CK_SYS   = 3'h1,
        TMC_CK_H16   = 3'h2,
        TMC_CK_H64   = 3'h3,
        TMC_CK_SUB0  = 3'h4,
        TMC_CK_SUB1  = 3'h5,
        TMC_CK_EXTR  = 3'h6,
        TMC_CK_EXTF  = 3'h7
    } tmc_cksel_t;

    // Register port access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] idx;
        logic [7:0] wdata;
    } tmc_req_t;

    // Compare match events
    typedef struct packed {
        logic matchA;
        logic matchP;
    } tmc_irq_t;

endpackage : tmc_pkg

// ---- hw/tmc_byte_latch.sv ----
// Shared low-byte holding buffer for the 16-bit register pairs
`timescale 1ns/10ps
`default_nettype none

module tmc_byte_latch #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Load port
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadData,
    // Contents
    output logic      [WIDTH-1:0] holdData
);

    logic [WIDTH-1:0] hold_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            hold_r <= '0;
        end else if (load) begin
            hold_r <= loadData;
        end
    end

    assign holdData = hold_r;

endmodule : tmc_byte_latch

`default_nettype wire

// ---- hw/tmc_core.sv ----
// Timer core: 16-bit up counter, compare A and P, output pin, byte register port
//
// Overview of operation
// - Counter runs upward, compares with comparators; equality raises interrupt.
// - A match may clear counter and change output pin per mode.
// - Separate interrupt events for comparator A and comparator P.
// - Three-bit select picks system ratio, high clock, sub clock or pin.
// - External pin counting uses rising or falling edge as selected.
// - External pin also triggers single pulse on types that offer it.
// - Compare output mode sets pin high, low or toggles on match.
// - Output pin carries PWM waveform in PWM mode.
// - Timer, compare output and PWM functions supported; single pulse optional.
// - High bytes direct; low bytes only through one 8-bit buffer.
// - Buffer-to-low-byte transfers only on high byte access.
// - Compare low byte write updates only the buffer.
// - Compare high byte write stores byte and copies buffer to low.
// - High byte read returns it and captures low byte into buffer.
// - Low byte read returns the buffer contents.
// - Period compare is 8 bits against counter bits 15..8; A is 16.
// - Counter cleared by on-bit rising, overflow or selected compare match.
`timescale 1ns/10ps
`default_nettype none

`include "tmc_cfg.svh"

module tmc_core #(
    parameter int CNT_W = 16,
    parameter bit HAS_PULSE = 1'b0
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              reset,
    // Clock sources: synchronous enables from the clock tree, and the raw external clock pin
    input  wire logic              clkHighTick,
    input  wire logic              clkSubTick,
    input  wire logic              timerExtClockPin,
    // Register port
    input  wire tmc_pkg::tmc_req_t req,
    output logic             [7:0] rdata,
    // Events and pin
    output tmc_pkg::tmc_irq_t      irq,
    output logic                   timerOutputPin
);

    localparam int HB = CNT_W - 8;

    // Control, counter, compare and state registers
    logic [7:0]       ctrl0_r;
    logic [7:0]       ctrl1_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [HB-1:0]    cmpAHi_r;
    logic [7:0]       cmpALo_r;
    logic [7:0]       perHi_r;
    logic [7:0]       perLo_r;
    logic             onDly_r;
    logic             extDly_r;
    logic [5:0]       pre_r;
    logic             pin_r;
    logic             pulseRun_r;
    logic [7:0]       rdata_r;
    tmc_pkg::tmc_irq_t irq_r;

    // Field decode
    wire                  pause   = ctrl0_r[`TMC_C0_PAUSE];
    wire                  on      = ctrl0_r[`TMC_C0_ON];
    wire tmc_pkg::tmc_cksel_t cks = tmc_pkg::tmc_cksel_t'(ctrl0_r[`TMC_C0_CKS_HI:`TMC_C0_CKS_LO]);
    wire tmc_pkg::tmc_mode_t mode = tmc_pkg::tmc_mode_t'(ctrl1_r[`TMC_C1_MODE_HI:`TMC_C1_MODE_LO]);
    wire [1:0]            ioSel   = ctrl1_r[`TMC_C1_IO_HI:`TMC_C1_IO_LO];
    wire                  oc      = ctrl1_r[`TMC_C1_OC];
    wire                  pol     = ctrl1_r[`TMC_C1_POL];
    wire                  dpx     = ctrl1_r[`TMC_C1_DPX];
    wire                  cclr    = ctrl1_r[`TMC_C1_CCLR];
    wire                  onRise  = on & ~onDly_r;

    // Register access strobes
    function automatic logic hit(input tmc_pkg::tmc_req_t r, input logic [2:0] idx);
        hit = r.idx == idx;
    endfunction : hit

    wire wrC0   = req.wr & hit(req, `TMC_IDX_CTRL0);
    wire wrC1   = req.wr & hit(req, `TMC_IDX_CTRL1);
    wire wrAHi  = req.wr & hit(req, `TMC_IDX_CMPA_HI);
    wire wrPHi  = req.wr & hit(req, `TMC_IDX_PER_HI);
    wire rdCHi  = req.rd & hit(req, `TMC_IDX_CNT_HI);
    wire rdAHi  = req.rd & hit(req, `TMC_IDX_CMPA_HI);
    wire rdPHi  = req.rd & hit(req, `TMC_IDX_PER_HI);
    // low byte writes land only in the buffer
    wire wrLo   = req.wr & (hit(req, `TMC_IDX_CMPA_LO) | hit(req, `TMC_IDX_PER_LO));

    // high read captures matching low byte
    wire       bufLoad = wrLo | rdCHi | rdAHi | rdPHi;
    wire [7:0] bufIn   = wrLo  ? req.wdata :
                         rdCHi ? count_r[7:0] :
                         rdAHi ? cmpALo_r : perLo_r;
    wire [7:0] holdByte;

    // one holding buffer shared by all pairs
    tmc_byte_latch #(.WIDTH(8)) u_hold (
        .mclk     (mclk),
        .reset    (reset),
        .load     (bufLoad),
        .loadData (bufIn),
        .holdData (holdByte)
    );

    // clock source selection; prescaler runs off the system clock
    wire extRise = timerExtClockPin & ~extDly_r;
    wire extFall = ~timerExtClockPin & extDly_r;
    wire tick4   = pre_r[1:0] == 2'h3;
    wire tickH16;
    wire tickH64;
    logic [5:0] hCnt_r;
    assign tickH16 = clkHighTick & (hCnt_r[3:0] == 4'(`TMC_DIV_H16 - 1));
    assign tickH64 = clkHighTick & (hCnt_r == 6'(`TMC_DIV_H64 - 1));
    logic srcTick;
    always_comb begin
        unique case (cks)
            tmc_pkg::TMC_CK_SYS4: srcTick = tick4;
            tmc_pkg::TMC_CK_SYS:  srcTick = 1'b1;
            tmc_pkg::TMC_CK_H16:  srcTick = tickH16;
            tmc_pkg::TMC_CK_H64:  srcTick = tickH64;
            tmc_pkg::TMC_CK_SUB0,
            tmc_pkg::TMC_CK_SUB1: srcTick = clkSubTick;
            // edge choice on the external pin
            tmc_pkg::TMC_CK_EXTR: srcTick = extRise;
            tmc_pkg::TMC_CK_EXTF: srcTick = extFall;
        endcase
    end

    // pin edge starts a single pulse when the type offers it
    wire trig     = HAS_PULSE & (cks == tmc_pkg::TMC_CK_EXTF ? extFall : extRise);
    wire countEn  = on & ~pause & srcTick & (~HAS_PULSE | ~dpx | pulseRun_r);

    // P compares upper 8 bits, A compares all bits
    wire [CNT_W-1:0] cmpA   = {cmpAHi_r, cmpALo_r};
    wire             matchA = count_r == cmpA;
    wire             matchP = count_r[CNT_W-1 -: 8] == perHi_r;
    wire             ovf    = &count_r;
    // the chosen comparator clears the counter
    wire             clrHit = cclr ? matchA : matchP;

    // on-bit rising, overflow, match clear the count
    always_comb begin
        count_nxt = count_r;
        if (onRise) begin
            count_nxt = '0;
        end else if (countEn) begin
            if (ovf | clrHit) begin
                count_nxt = '0;
            end else begin
                count_nxt = count_r + CNT_W'(1);
            end
        end
    end

    // compare output actions; PWM drive from A duty
    logic pin_nxt;
    always_comb begin
        pin_nxt = pin_r;
        if (onRise) begin
            pin_nxt = (mode == tmc_pkg::TMC_MODE_PWM) ? ~pol ^ oc : oc;
        end else if (countEn) begin
            unique case (mode)
                tmc_pkg::TMC_MODE_CMP: begin
                    if (matchA) begin
                        unique case (ioSel)
                            2'h0: pin_nxt = pin_r;
                            2'h1: pin_nxt = 1'b0;
                            2'h2: pin_nxt = 1'b1;
                            2'h3: pin_nxt = ~pin_r;
                        endcase
                    end
                end
                tmc_pkg::TMC_MODE_PWM: begin
                    unique case (ioSel)
                        2'h0: pin_nxt = ~oc;
                        2'h1: pin_nxt = oc;
                        2'h2: pin_nxt = (clrHit | ovf) ? oc : (matchA ? ~oc : pin_r);
                        2'h3: pin_nxt = pin_r;
                    endcase
                end
                tmc_pkg::TMC_MODE_UNDEF,
                tmc_pkg::TMC_MODE_TIMER: pin_nxt = pin_r;
            endcase
        end
    end

    // high bytes read directly; low bytes read the buffer
    logic [7:0] rd_nxt;
    always_comb begin
        unique case (req.idx)
            `TMC_IDX_CTRL0:   rd_nxt = ctrl0_r;
            `TMC_IDX_CTRL1:   rd_nxt = ctrl1_r;
            `TMC_IDX_CNT_HI:  rd_nxt = count_r[CNT_W-1 -: 8];
            `TMC_IDX_CMPA_HI: rd_nxt = cmpAHi_r[7:0];
            `TMC_IDX_PER_HI:  rd_nxt = perHi_r;
            default:          rd_nxt = holdByte;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl0_r    <= `TMC_CTRL0_RST;
            ctrl1_r    <= `TMC_CTRL1_RST;
            count_r    <= '0;
            cmpAHi_r   <= '0;
            cmpALo_r   <= 8'h00;
            perHi_r    <= 8'h00;
            perLo_r    <= 8'h00;
            onDly_r    <= 1'b0;
            extDly_r   <= 1'b0;
            pre_r      <= 6'h00;
            hCnt_r     <= 6'h00;
            pin_r      <= 1'b0;
            pulseRun_r <= 1'b0;
            rdata_r    <= 8'h00;
            irq_r      <= '0;
        end else begin
            if (wrC0) ctrl0_r <= req.wdata & `TMC_CTRL0_MASK;
            if (wrC1) ctrl1_r <= req.wdata;
            // high write also moves buffer into low byte
            if (wrAHi) begin
                cmpAHi_r <= req.wdata;
                cmpALo_r <= holdByte;
            end
            // low byte only changes with its high byte write
            if (wrPHi) begin
                perHi_r <= req.wdata;
                perLo_r <= holdByte;
            end
            onDly_r  <= on;
            extDly_r <= timerExtClockPin;
            pre_r    <= pre_r + 6'h01;
            if (clkHighTick) hCnt_r <= hCnt_r + 6'h01;
            count_r  <= count_nxt;
            pin_r    <= pin_nxt;
            // Pulse runs from the trigger until the A match ends it
            if (trig & on & dpx) pulseRun_r <= 1'b1;
            else if (~on | (countEn & matchA)) pulseRun_r <= 1'b0;
            if (req.rd) rdata_r <= rd_nxt;
            // one-cycle event per comparator on a counted match
            irq_r.matchA <= countEn & matchA;
            irq_r.matchP <= countEn & matchP;
        end
    end

    // all functions share one pin register
    assign rdata          = rdata_r;
    assign irq            = irq_r;
    assign timerOutputPin = pin_r;

endmodule : tmc_core

`default_nettype wire

// ---- testbench/tmc_core_asserts.sv ----
// Port assertions for the timer core
`timescale 1ns/10ps
`default_nettype none

module tmc_core_asserts (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              reset,
    // Register port, events and pin
    input wire tmc_pkg::tmc_req_t req,
    input wire logic        [7:0] rdata,
    input wire tmc_pkg::tmc_irq_t irq,
    input wire logic              timerOutputPin
);
    logic [7:0] ctl0_r;
    logic [7:0] ctl1_r;
    wire        wrCtl0  = req.wr && req.idx == 3'h0;
    wire        wrCtl1  = req.wr && req.idx == 3'h1;
    wire        run     = ctl0_r[3] && !ctl0_r[7];
    wire        cmpMode = ctl1_r[7:6] == 2'h0;

    // Shadow of the control bytes, so rules can be keyed on mode
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctl0_r <= 8'h00;
            ctl1_r <= 8'h00;
        end else begin
            ctl0_r <= wrCtl0 ? req.wdata : ctl0_r;
            ctl1_r <= wrCtl1 ? req.wdata : ctl1_r;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_RDATA_HOLD: assert property (
        !req.rd |=> $stable(rdata)) else $error("read data moved without a read");
    AST_CTL0_UNUSED: assert property (
        req.rd && req.idx == 3'h0 |=> rdata[2:0] == 3'h0) else $error("ctrl0 low bits set");
    AST_LOW_PAIR: assert property (
        req.wr && req.idx == 3'h4 ##1 req.wr && req.idx == 3'h5 ##1
        req.rd && req.idx == 3'h5 ##1 req.rd && req.idx == 3'h4
        |=> rdata == $past(req.wdata, 4)) else $error("low byte pair lost");
    AST_HIGH_WRITE: assert property (
        req.wr && req.idx[2] && req.idx[0] ##1 req.rd && req.idx == $past(req.idx)
        |=> rdata == $past(req.wdata, 2)) else $error("high byte not stored");
    AST_IDLE_QUIET: assert property (
        !run ##1 !run ##1 !run |-> irq == '0) else $error("event while stopped");
    AST_ON_PIN: assert property (
        wrCtl0 && req.wdata[3] && !ctl0_r[3] && cmpMode
        |-> ##[1:2] timerOutputPin == ctl1_r[3]) else $error("pin not set to initial");
    AST_PIN_CAUSE: assert property (
        cmpMode && $past(cmpMode) && ctl0_r[3] && $past(ctl0_r[3]) && $past(ctl0_r[3], 2)
        && $past(ctl0_r[3], 3) && $changed(timerOutputPin)
        |-> irq.matchA || $past(irq.matchA)) else $error("pin moved without match");
    AST_PIN_NOCHANGE: assert property (
        cmpMode && $past(cmpMode) && ctl1_r[5:4] == 2'h0 && $past(ctl1_r[5:4]) == 2'h0
        && ctl0_r[3] && $past(ctl0_r[3]) && $past(ctl0_r[3], 2) && $past(ctl0_r[3], 3)
        |-> $stable(timerOutputPin)) else $error("pin moved in no-change setting");

    COV_MATCH_A: cover property (irq.matchA);
    COV_MATCH_P: cover property (irq.matchP);
    COV_PIN_RISE: cover property ($rose(timerOutputPin));
endmodule : tmc_core_asserts

bind tmc_core tmc_core_asserts u_chk (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata),
    .irq(irq), .timerOutputPin(timerOutputPin));

`default_nettype wire

// ---- testbench/tmc_core_tb.sv ----
// Self-checking bench for the timer core
`timescale 1ns/10ps
`default_nettype none

module tmc_core_tb;
    typedef struct {logic [2:0] idx; logic [7:0] wd; logic [7:0] ex;} tmc_row_t;

    logic              mclk;
    logic              reset;
    logic              highTick;
    logic              subTick;
    logic              extPin;
    logic              pin;
    logic        [7:0] rdata;
    tmc_pkg::tmc_req_t req;
    tmc_pkg::tmc_irq_t irq;
    int                err_count;
    int                n_tests;
    int                cycles;
    int                n;
    logic              sawA;
    logic              sawP;
    // Control, read-only counter, high bytes
    tmc_row_t rows [7] = '{'{3'h0, 8'hFF, 8'hF8}, '{3'h3, 8'hAA, 8'h00},
        '{3'h1, 8'hA5, 8'hA5}, '{3'h5, 8'h12, 8'h12}, '{3'h7, 8'h9C, 8'h9C},
        '{3'h0, 8'h00, 8'h00}, '{3'h1, 8'h00, 8'h00}};
    // Clock selects and their tick period in mclk cycles
    logic [7:0]        ckSel [4] = '{8'h08, 8'h28, 8'h48, 8'h38};
    int                ckPer [4] = '{4, 256, 128, 1024};

    tmc_core dut (.mclk(mclk), .reset(reset), .clkHighTick(highTick), .clkSubTick(subTick),
        .timerExtClockPin(extPin), .req(req), .rdata(rdata), .irq(irq), .timerOutputPin(pin));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard: the full run needs about 3100 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (irq.matchA) sawA <= 1'b1;
        if (irq.matchP) sawP <= 1'b1;
        if (cycles == 8000) begin
            err_count++;
            finish_test();
        end
    end

    always @(negedge mclk) begin
        highTick <= cycles[3:0] == 4'h0;
        subTick  <= cycles[6:0] == 7'h0;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request is held until the next call, so calls run back to back
    task automatic acc(input logic w, input logic [2:0] idx, input logic [7:0] wd);
        @(negedge mclk);
        req = '{w, !w, idx, wd};
        @(posedge mclk);
        #1;
    endtask : acc

    task automatic rd(input string name, input logic [2:0] idx, input logic [7:0] exp);
        acc(1'b0, idx, 8'h00);
        check(name, {8'h00, rdata}, {8'h00, exp});
    endtask : rd

    task automatic idle(input int k);
        @(negedge mclk);
        req = '0;
        repeat (k) @(posedge mclk);
        #1;
    endtask : idle

    task automatic waitFor(input bit selA, output int k);
        k = 0;
        do begin
            @(posedge mclk);
            #1;
            k++;
        end while (!(selA ? irq.matchA : irq.matchP) && k < 1100);
        if (k >= 1100) begin
            err_count++;
            $display("ERROR waitFor expected event seen none");
        end
    endtask : waitFor

    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        reset = 1'b1;
        req = '0;
        extPin = 1'b0;
        highTick = 1'b0;
        subTick = 1'b0;
        err_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        #1;
        check("resetOutputs", {5'h00, rdata, irq, pin}, 16'h0000);
        foreach (rows[i]) begin
            acc(1'b1, rows[i].idx, rows[i].wd);
            rd("rowRead", rows[i].idx, rows[i].ex);
        end
        acc(1'b1, 3'h4, 8'h34);
        acc(1'b1, 3'h5, 8'h12);
        rd("aHigh", 3'h5, 8'h12);
        rd("aLow", 3'h4, 8'h34);
        acc(1'b1, 3'h4, 8'h56);
        rd("aHighAgain", 3'h5, 8'h12);
        rd("aLowKept", 3'h4, 8'h34);
        // Toggle on A match, clear on A, sys clock
        acc(1'b1, 3'h4, 8'h05);
        acc(1'b1, 3'h5, 8'h00);
        acc(1'b1, 3'h7, 8'h01);
        acc(1'b1, 3'h1, 8'h31);
        acc(1'b1, 3'h0, 8'h18);
        idle(0);
        sawP = 1'b0;
        waitFor(1'b1, n);
        idle(2);
        check("pinToggled", {15'h0000, pin}, 16'h0001);
        waitFor(1'b1, n);
        check("aPeriod", n[15:0], 16'h0004);
        check("pSilent", {15'h0000, sawP}, 16'h0000);
        // Clear on P: high byte only, so period is 0x101 ticks
        acc(1'b1, 3'h0, 8'h00);
        acc(1'b1, 3'h1, 8'h00);
        acc(1'b1, 3'h4, 8'hFF);
        acc(1'b1, 3'h5, 8'hFF);
        acc(1'b1, 3'h0, 8'h18);
        idle(0);
        sawA = 1'b0;
        waitFor(1'b0, n);
        waitFor(1'b0, n);
        check("pPeriod", n[15:0], 16'h0101);
        check("aSilent", {15'h0000, sawA}, 16'h0000);
        // Pin clock: two rising edges, then one falling edge
        acc(1'b1, 3'h0, 8'h00);
        acc(1'b1, 3'h0, 8'h68);
        idle(2);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) acc(1'b1, 3'h0, 8'h78);
            idle(1);
            @(negedge mclk) extPin = 1'b1;
            repeat (3) @(negedge mclk);
            extPin = 1'b0;
            repeat (3) @(negedge mclk);
        end
        rd("cntHigh", 3'h3, 8'h00);
        rd("cntLow", 3'h2, 8'h03);
        // PWM: pin goes active at the P clear and inactive after A+1 ticks
        acc(1'b1, 3'h0, 8'h00);
        acc(1'b1, 3'h1, 8'hA8);
        acc(1'b1, 3'h4, 8'h10);
        acc(1'b1, 3'h5, 8'h00);
        acc(1'b1, 3'h6, 8'h00);
        acc(1'b1, 3'h7, 8'h01);
        acc(1'b1, 3'h0, 8'h18);
        idle(0);
        waitFor(1'b0, n);
        check("pwmActive", {15'h0000, pin}, 16'h0001);
        waitFor(1'b1, n);
        check("pwmDuty", n[15:0], 16'h0011);
        check("pwmInactive", {15'h0000, pin}, 16'h0000);
        // Clock selects: A of zero gives one event per counter tick
        acc(1'b1, 3'h0, 8'h00);
        acc(1'b1, 3'h1, 8'h01);
        acc(1'b1, 3'h4, 8'h00);
        acc(1'b1, 3'h5, 8'h00);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 3'h0, ckSel[i]);
            idle(0);
            waitFor(1'b1, n);
            waitFor(1'b1, n);
            check("tickPeriod", n[15:0], ckPer[i][15:0]);
        end
        // Reset in mid-run returns outputs and counter to zero
        @(negedge mclk);
        reset = 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        #1;
        check("midReset", {5'h00, rdata, irq, pin}, 16'h0000);
        rd("cntAfterReset", 3'h3, 8'h00);
        rd("ctrlAfterReset", 3'h0, 8'h00);
        idle(2);
        finish_test();
    end
endmodule : tmc_core_tb

`default_nettype wire
